/* File: hw/sim_presence_control.sv */
// Contract
// - only one of two card slots active
// - tray withdrawn: shut card interface down immediately
// - first init attempt finished within one second
// - high at start: track tray, low means none
// - no tray: retry periodically, resume when high
// - low at start: still attempt initialization
// - low mode loss: emergency only until restart
// - selectable card clock rate, device drives reset
// - shared io line driven only on own turn
`default_nettype none
module sim_presence_control #(
    parameter int unsigned STARTUP_LIMIT =
        sim_presence_pkg::STARTUP_LIMIT_CYCLES,
    parameter int unsigned RETRY_WAIT    = sim_presence_pkg::RETRY_CYCLES,
    parameter int unsigned ATR_WAIT      = sim_presence_pkg::ATR_WAIT_CLOCKS
) (
    input  wire logic                                ref_clk,
    input  wire logic                                rst_n,
    input  wire logic                                card_tray_detect,
    input  wire logic                                slot_select,
    input  wire logic [sim_presence_pkg::RATE_W-1:0] clock_rate_sel,
    input  wire logic                                tx_turn,
    input  wire logic                                tx_bit,
    input  wire logic                                card_no_response,
    input  wire logic                                card_io_in_a,
    input  wire logic                                card_io_in_b,
    output logic                                     card_supply_a,
    output logic                                     card_supply_b,
    output logic                                     card_clock_a,
    output logic                                     card_clock_b,
    output logic                                     card_reset_n_a,
    output logic                                     card_reset_n_b,
    output logic                                     card_io_out_a,
    output logic                                     card_io_out_b,
    output logic                                     card_io_oe_a,
    output logic                                     card_io_oe_b,
    output logic                                     rx_bit,
    output logic                                     card_ready,
    output logic                                     emergency_only,
    output logic                                     start_tray_high,
    output logic                                     init_done
);
    localparam int unsigned W = sim_presence_pkg::TMR_W;

    function automatic logic [1:0] slot_mask(input logic s);
        slot_mask = (s == sim_presence_pkg::SLOT_HOST) ? 2'h2 : 2'h1;
    endfunction

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic       tray_meta, tray_sync, tray_prev;
    logic [1:0] io_meta, io_sync;
    logic       next_tray_meta, next_tray_sync, next_tray_prev;
    logic [1:0] next_io_meta, next_io_sync;

    always_comb begin
        next_tray_meta = card_tray_detect;
        next_tray_sync = tray_meta;
        next_tray_prev = tray_sync;
        next_io_meta   = {card_io_in_b, card_io_in_a};
        next_io_sync   = io_meta;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tray_meta <= 1'b0;
            tray_sync <= 1'b0;
            tray_prev <= 1'b0;
            io_meta   <= 2'h3;
            io_sync   <= 2'h3;
        end else begin
            tray_meta <= next_tray_meta;
            tray_sync <= next_tray_sync;
            tray_prev <= next_tray_prev;
            io_meta   <= next_io_meta;
            io_sync   <= next_io_sync;
        end
    end

    // ************************************************************
    // card clock divider
    // ************************************************************
    sim_presence_pkg::state_type state, next_state;
    logic clk_level, clk_rise, clk_run;

    assign clk_run = (state == sim_presence_pkg::st_reset)
                  || (state == sim_presence_pkg::st_atr)
                  || (state == sim_presence_pkg::st_active);

    card_clock_gen u_clk (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .run      (clk_run),
        .rate_sel (clock_rate_sel),
        .card_clk (clk_level),
        .rise     (clk_rise)
    );

    // ************************************************************
    // session control
    // ************************************************************
    logic [W-1:0] tmr, next_tmr, boot_cnt, next_boot_cnt;
    logic         mode_high, next_mode_high;
    logic         slot, next_slot;
    logic         done, next_done;
    logic         powered, withdrawn, deadline, fail, slot_io;

    assign powered   = clk_run || (state == sim_presence_pkg::st_power);
    assign withdrawn = powered
                    && ((mode_high && !tray_sync)
                     || (tray_prev && !tray_sync));
    assign deadline  = !done && (boot_cnt == W'(STARTUP_LIMIT - 1));
    assign slot_io   = io_sync[slot];

    always_comb begin
        next_state     = state;
        next_tmr       = tmr;
        next_mode_high = mode_high;
        next_slot      = slot;
        next_done      = done;
        next_boot_cnt  = boot_cnt;
        fail           = 1'b0;
        if (boot_cnt != W'(STARTUP_LIMIT))
            next_boot_cnt = boot_cnt + W'(1);
        case (state)
            sim_presence_pkg::st_boot: begin
                next_tmr = tmr + W'(1);
                if (tmr == W'(sim_presence_pkg::SETTLE_CYCLES - 1)) begin
                    next_mode_high = tray_sync;
                    next_slot      = slot_select;
                    next_tmr       = '0;
                    next_state     = sim_presence_pkg::st_power;
                end
            end
            sim_presence_pkg::st_power: begin
                next_tmr = tmr + W'(1);
                if (tmr == W'(sim_presence_pkg::POWER_SETTLE_CYCLES - 1))
                begin
                    next_tmr   = '0;
                    next_state = sim_presence_pkg::st_reset;
                end
            end
            sim_presence_pkg::st_reset: begin
                if (clk_rise) begin
                    next_tmr = tmr + W'(1);
                    if (tmr == W'(sim_presence_pkg::RESET_HOLD_CLOCKS - 1))
                    begin
                        next_tmr   = '0;
                        next_state = sim_presence_pkg::st_atr;
                    end
                end
            end
            sim_presence_pkg::st_atr: begin
                if (!slot_io) begin
                    next_done  = 1'b1;
                    next_state = sim_presence_pkg::st_active;
                end else if (clk_rise) begin
                    next_tmr = tmr + W'(1);
                    if (tmr == W'(ATR_WAIT - 1))
                        fail = 1'b1;
                end
            end
            sim_presence_pkg::st_active: begin
                if (card_no_response)
                    fail = 1'b1;
            end
            sim_presence_pkg::st_idle: begin
                next_tmr = tmr + W'(1);
                if (tmr == W'(RETRY_WAIT - 1)) begin
                    next_tmr = '0;
                    if (tray_sync)
                        next_state = sim_presence_pkg::st_power;
                end
            end
            sim_presence_pkg::st_emergency: begin
                next_state = sim_presence_pkg::st_emergency;
            end
            default: begin
                next_state = sim_presence_pkg::st_boot;
            end
        endcase
        if (withdrawn || (deadline && powered))
            fail = 1'b1;
        if (deadline)
            next_done = 1'b1;
        if (fail) begin
            next_done  = 1'b1;
            next_tmr   = '0;
            next_state = mode_high ? sim_presence_pkg::st_idle
                                   : sim_presence_pkg::st_emergency;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= sim_presence_pkg::st_boot;
            tmr       <= '0;
            boot_cnt  <= '0;
            mode_high <= 1'b0;
            slot      <= sim_presence_pkg::SLOT_ONBOARD;
            done      <= 1'b0;
        end else begin
            state     <= next_state;
            tmr       <= next_tmr;
            boot_cnt  <= next_boot_cnt;
            mode_high <= next_mode_high;
            slot      <= next_slot;
            done      <= next_done;
        end
    end

    // ************************************************************
    // registered pin outputs
    // ************************************************************
    logic [1:0] sup, clk, rstn, oe, dout;
    logic [1:0] next_sup, next_clk, next_rstn, next_oe, next_dout;
    logic       next_rx, next_ready, next_emerg;

    always_comb begin
        next_sup  = powered ? slot_mask(slot) : 2'h0;
        next_clk  = (clk_run && clk_level) ? slot_mask(slot) : 2'h0;
        next_rstn = ((state == sim_presence_pkg::st_atr)
                  || (state == sim_presence_pkg::st_active))
                  ? slot_mask(slot) : 2'h0;
        next_oe   = ((state == sim_presence_pkg::st_active) && tx_turn)
                  ? slot_mask(slot) : 2'h0;
        next_dout  = {tx_bit, tx_bit};
        next_rx    = slot_io;
        next_ready = (state == sim_presence_pkg::st_active);
        next_emerg = (state == sim_presence_pkg::st_emergency);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sup            <= 2'h0;
            clk            <= 2'h0;
            rstn           <= 2'h0;
            oe             <= 2'h0;
            dout           <= 2'h3;
            rx_bit         <= 1'b1;
            card_ready     <= 1'b0;
            emergency_only <= 1'b0;
        end else begin
            sup            <= next_sup;
            clk            <= next_clk;
            rstn           <= next_rstn;
            oe             <= next_oe;
            dout           <= next_dout;
            rx_bit         <= next_rx;
            card_ready     <= next_ready;
            emergency_only <= next_emerg;
        end
    end

    assign {card_supply_b, card_supply_a}   = sup;
    assign {card_clock_b, card_clock_a}     = clk;
    assign {card_reset_n_b, card_reset_n_a} = rstn;
    assign {card_io_oe_b, card_io_oe_a}     = oe;
    assign {card_io_out_b, card_io_out_a}   = dout;
    assign start_tray_high = mode_high;
    assign init_done       = done;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_one_slot: assert property (!(card_supply_a && card_supply_b))
        else $error("both card slots powered");
    a_withdraw_shut: assert property (
        mode_high && powered && !tray_sync
        |-> ##2 !card_supply_a && !card_supply_b)
        else $error("supply stayed on after withdrawal");
    a_boot_deadline: assert property (
        boot_cnt == W'(STARTUP_LIMIT) |-> init_done)
        else $error("first init not finished by deadline");
    a_no_tray_ready: assert property (
        mode_high && !tray_sync && state != sim_presence_pkg::st_boot
        |=> ##1 !card_ready)
        else $error("card ready without tray");
    a_retry_power: assert property (
        state == sim_presence_pkg::st_idle && tmr == W'(RETRY_WAIT - 1)
        && tray_sync |=> state == sim_presence_pkg::st_power)
        else $error("retry did not restart power up");
    a_low_mode_try: assert property (
        $past(state == sim_presence_pkg::st_boot)
        && state != sim_presence_pkg::st_boot
        |-> state == sim_presence_pkg::st_power)
        else $error("no init attempt after boot");
    a_emergency_hold: assert property (
        emergency_only |=> emergency_only && !card_supply_a
        && !card_supply_b)
        else $error("emergency mode left before restart");
    a_reset_order: assert property (
        $rose(card_reset_n_a || card_reset_n_b)
        |-> $past(state == sim_presence_pkg::st_atr))
        else $error("card reset released out of order");
    a_io_turn: assert property (
        (card_io_oe_a || card_io_oe_b)
        |-> $past(tx_turn) && card_ready)
        else $error("io driven outside own turn");
    a_tray_sync: assert property (
        $past(rst_n, 2) |-> tray_sync == $past(card_tray_detect, 2))
        else $error("tray detect not two-stage synchronised");

    c_active: cover property (state == sim_presence_pkg::st_active);
    c_emergency: cover property (emergency_only);
    c_resume: cover property (state == sim_presence_pkg::st_idle
        ##1 state == sim_presence_pkg::st_power);
endmodule
`default_nettype wire

/* File: hw/sim_presence_pkg.sv */
`default_nettype none
package sim_presence_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int unsigned CLK_HZ               = 10_000_000;
    localparam int unsigned STARTUP_LIMIT_MS     = 1000;
    localparam int unsigned STARTUP_LIMIT_CYCLES =
        CLK_HZ / 1000 * STARTUP_LIMIT_MS;
    localparam int unsigned RETRY_INTERVAL_MS    = 500;
    localparam int unsigned RETRY_CYCLES         =
        CLK_HZ / 1000 * RETRY_INTERVAL_MS;
    localparam int unsigned POWER_SETTLE_US      = 10;
    localparam int unsigned POWER_SETTLE_CYCLES  =
        CLK_HZ / 1_000_000 * POWER_SETTLE_US;
    localparam int unsigned RESET_HOLD_CLOCKS    = 400;
    localparam int unsigned ATR_WAIT_CLOCKS      = 40000;
    localparam int unsigned SETTLE_CYCLES        = 3;

    // ************************************************************
    // widths and codes
    // ************************************************************
    localparam int unsigned TMR_W    = 24;
    localparam int unsigned DIV_W    = 4;
    localparam int unsigned RATE_W   = 2;
    localparam logic [DIV_W-1:0] DIV_ONE = 4'h1;
    localparam logic SLOT_ONBOARD = 1'b0;
    localparam logic SLOT_HOST    = 1'b1;

    typedef enum logic [6:0] {
        st_boot      = 7'h01,
        st_power     = 7'h02,
        st_reset     = 7'h04,
        st_atr       = 7'h08,
        st_active    = 7'h10,
        st_idle      = 7'h20,
        st_emergency = 7'h40
    } state_type;

endpackage
`default_nettype wire

/* File: hw/card_clock_gen.sv */
`default_nettype none
module card_clock_gen (
    input  wire logic                                  ref_clk,
    input  wire logic                                  rst_n,
    input  wire logic                                  run,
    input  wire logic [sim_presence_pkg::RATE_W-1:0]   rate_sel,
    output logic                                       card_clk,
    output logic                                       rise
);
    logic [sim_presence_pkg::DIV_W-1:0] cnt;
    logic [sim_presence_pkg::DIV_W-1:0] next_cnt;
    logic                               next_card_clk;
    logic [sim_presence_pkg::DIV_W-1:0] limit;

    // half period is 2**rate_sel reference cycles
    assign limit = (sim_presence_pkg::DIV_ONE << rate_sel)
                   - sim_presence_pkg::DIV_ONE;
    assign rise  = run && !card_clk && (cnt == limit);

    always_comb begin
        next_cnt      = cnt;
        next_card_clk = card_clk;
        if (!run) begin
            next_cnt      = '0;
            next_card_clk = 1'b0;
        end else if (cnt == limit) begin
            next_cnt      = '0;
            next_card_clk = !card_clk;
        end else begin
            next_cnt = cnt + sim_presence_pkg::DIV_ONE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt      <= '0;
            card_clk <= 1'b0;
        end else begin
            cnt      <= next_cnt;
            card_clk <= next_card_clk;
        end
    end
endmodule
`default_nettype wire

/* File: verification/card_holder_model.sv */
`default_nettype none
module card_holder_model (
    input  wire logic       ref_clk,
    input  wire logic       tray_in,
    input  wire logic       fitted,
    input  wire logic [7:0] answer_wait,
    input  wire logic       supply,
    input  wire logic       card_clock,
    input  wire logic       card_reset_n,
    input  wire logic       dev_oe,
    input  wire logic       dev_out,
    output logic            tray_detect,
    output logic            io_level
);
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // card answer after reset and holder switch
    // ************************************************************
    logic       clk_q = 1'b0;
    logic       drive = 1'b0;
    logic [7:0] rises = 8'h00;

    assign tray_detect = tray_in;
    // pull-up when nobody drives the line
    assign io_level = dev_oe ? dev_out
                    : ((drive && fitted && supply) ? 1'b0 : 1'b1);

    always @(posedge ref_clk) begin
        clk_q <= card_clock;
        if (!(supply && fitted && card_reset_n)) begin
            rises <= 8'h00;
            drive <= 1'b0;
        end else if (card_clock && !clk_q) begin
            if (rises != 8'hFF) begin
                rises <= rises + 8'h01;
            end
            // start bit only while the device has let go
            drive <= !dev_oe && rises >= answer_wait
                     && rises < answer_wait + 8'h04;
        end
    end
endmodule
`default_nettype wire

/* File: verification/sim_presence_control_bench.sv */
`default_nettype none
module sim_presence_control_bench;
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // harness
    // ************************************************************
    localparam int STARTUP = 6000;
    localparam int RETRY   = 200;

    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       tray_in = 1'b1;
    logic       fitted = 1'b1;
    logic [7:0] answer_wait = 8'h0A;
    logic       slot_select = 1'b0;
    logic [1:0] clock_rate_sel = 2'h2;
    logic       tx_turn = 1'b0;
    logic       tx_bit = 1'b0;
    logic       card_no_response = 1'b0;
    logic       card_tray_detect;
    logic       io_a;
    logic       supply_a, supply_b, clk_a, clk_b, rst_a, rst_b;
    logic       out_a, out_b, oe_a, oe_b;
    logic       rx_bit, card_ready, emergency_only, start_tray_high;
    logic       init_done;
    int         n_fail = 0;
    int         tests_run = 0;

    always #50 ref_clk = ~ref_clk;

    sim_presence_control #(
        .STARTUP_LIMIT (STARTUP),
        .RETRY_WAIT    (RETRY),
        .ATR_WAIT      (50)
    ) i_dut (
        .ref_clk          (ref_clk),
        .rst_n            (rst_n),
        .card_tray_detect (card_tray_detect),
        .slot_select      (slot_select),
        .clock_rate_sel   (clock_rate_sel),
        .tx_turn          (tx_turn),
        .tx_bit           (tx_bit),
        .card_no_response (card_no_response),
        .card_io_in_a     (io_a),
        .card_io_in_b     (oe_b ? out_b : 1'b1),
        .card_supply_a    (supply_a),
        .card_supply_b    (supply_b),
        .card_clock_a     (clk_a),
        .card_clock_b     (clk_b),
        .card_reset_n_a   (rst_a),
        .card_reset_n_b   (rst_b),
        .card_io_out_a    (out_a),
        .card_io_out_b    (out_b),
        .card_io_oe_a     (oe_a),
        .card_io_oe_b     (oe_b),
        .rx_bit           (rx_bit),
        .card_ready       (card_ready),
        .emergency_only   (emergency_only),
        .start_tray_high  (start_tray_high),
        .init_done        (init_done)
    );

    card_holder_model i_holder (
        .ref_clk      (ref_clk),
        .tray_in      (tray_in),
        .fitted       (fitted),
        .answer_wait  (answer_wait),
        .supply       (supply_a),
        .card_clock   (clk_a),
        .card_reset_n (rst_a),
        .dev_oe       (oe_a),
        .dev_out      (out_a),
        .tray_detect  (card_tray_detect),
        .io_level     (io_a)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_on(input int which, input logic want, input int lim);
        logic seen;
        for (int i = 0; i <= lim; i++) begin
            case (which)
                0: seen = card_ready;
                1: seen = init_done;
                default: seen = clk_b;
            endcase
            if (seen === want) return;
            step(1);
        end
        n_fail++;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, want);
        wrap_up();
    endtask

    task automatic boot(input logic tray, input logic fit, input logic slot,
                        input logic [1:0] rate);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        tray_in <= tray;
        fitted <= fit;
        slot_select <= slot;
        clock_rate_sel <= rate;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_rates;
        int n;
        for (int r = 0; r < 4; r++) begin
            boot(1'b1, 1'b1, 1'b1, r[1:0]);
            wait_on(2, 1'b1, 300);
            n = 0;
            while (clk_b === 1'b1 && n < 40) begin
                step(1);
                n++;
            end
            check(n[7:0], 8'h01 << r);
            check({supply_a, clk_a, oe_a}, 8'h00);
        end
    endtask

    task automatic t_init_high;
        boot(1'b1, 1'b1, 1'b0, 2'h2);
        wait_on(0, 1'b1, STARTUP);
        check(start_tray_high, 8'h01);
        check(init_done, 8'h01);
        check({supply_a, rst_a, emergency_only}, 8'h06);
        check({supply_b, clk_b, rst_b, oe_b}, 8'h00);
    endtask

    task automatic t_io_turn;
        step(50);
        @(posedge ref_clk);
        tx_turn <= 1'b1;
        tx_bit <= 1'b0;
        step(1);
        check({oe_a, out_a}, 8'h02);
        @(posedge ref_clk);
        tx_bit <= 1'b1;
        step(1);
        check({oe_a, out_a}, 8'h03);
        @(posedge ref_clk);
        tx_turn <= 1'b0;
        step(6);
        check({oe_a, rx_bit}, 8'h01);
    endtask

    task automatic t_withdraw;
        @(posedge ref_clk);
        tray_in <= 1'b0;
        step(2);
        check(supply_a, 8'h01);
        step(3);
        check({supply_a, clk_a, rst_a, oe_a, card_ready}, 8'h00);
        @(posedge ref_clk);
        fitted <= 1'b0;
        step(3 * RETRY);
        check(supply_a, 8'h00);
        @(posedge ref_clk);
        fitted <= 1'b1;
        tray_in <= 1'b1;
        wait_on(0, 1'b1, RETRY + STARTUP);
        check(emergency_only, 8'h00);
    endtask

    task automatic t_low_mode;
        answer_wait <= 8'h28;
        boot(1'b0, 1'b1, 1'b0, 2'h2);
        wait_on(0, 1'b1, STARTUP);
        check(start_tray_high, 8'h00);
        @(posedge ref_clk);
        card_no_response <= 1'b1;
        @(posedge ref_clk);
        card_no_response <= 1'b0;
        step(4);
        check({emergency_only, card_ready, supply_a}, 8'h04);
        @(posedge ref_clk);
        tray_in <= 1'b1;
        step(3 * RETRY);
        check({emergency_only, supply_a, clk_a}, 8'h04);
    endtask

    task automatic t_low_nocard;
        answer_wait <= 8'h0A;
        boot(1'b0, 1'b0, 1'b0, 2'h2);
        wait_on(1, 1'b1, STARTUP);
        // flag and supply follow the state one edge after init_done
        step(2);
        check({card_ready, emergency_only, supply_a}, 8'h02);
        boot(1'b0, 1'b1, 1'b0, 2'h2);
        wait_on(0, 1'b1, STARTUP);
        check(emergency_only, 8'h00);
    endtask

    initial begin
        t_rates();
        t_init_high();
        t_io_turn();
        t_withdraw();
        t_low_mode();
        t_low_nocard();
        wrap_up();
    end
endmodule
`default_nettype wire
